// ---- core/vbcirq_cfg.svh ----
// Constants for the vertical blank, chroma control and interrupt B register slice.
// Behaviour
// - Blank end byte is signed line offset.
// - Blank output ends at adjusted end line.
// - Adjusted end times the luma bypass window.
// - Non-adaptive comb decode from enable and mode.
// - Adaptive comb picks coefficients and fallback.
// - Standard selects default adaptive comb setting.
// - Oscillator reset bit pulses, reads zero.
// - Phase reset flagged on next designated line.
// - Auto chroma gain field decoded four ways.
// - Chroma filter select picks output bandwidth.
// - Clear register zeroes status bits written one.
// - Eight sources share bit positions everywhere.
// - Mask gates pin; masks reset to zero.
// - Status records events regardless of mask.
// - Pin active when status AND mask nonzero.
// - Config bit zero selects polarity, default high.
// - Active low: pull low or float.
// - Active high: drive high or low.
// - Standard blank lines come from fixed table.
// - Latched flags readable in status register.
`ifndef VBCIRQ_CFG_SVH
`define VBCIRQ_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VBC_OFS_VBLANK_END 8'h19
`define VBC_OFS_CHROMA_ONE 8'h1A
`define VBC_OFS_CHROMA_TWO 8'h1B
`define VBC_OFS_IRQ_CLEAR 8'h1C
`define VBC_OFS_IRQ_MASK 8'h1D
`define VBC_OFS_IRQ_CONFIG 8'h1E
`define VBC_OFS_IRQ_STATUS 8'h85

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define VBC_C1_OSC_RESET_BIT 4
`define VBC_RST_VBLANK_END 8'h00
`define VBC_RST_C1_NTSC 8'h2C
`define VBC_RST_C1_PAL 8'h6C
`define VBC_RST_CHROMA_TWO 2'h0
`define VBC_RST_MASK 8'h00
`define VBC_RST_POLARITY 1'h1

// ****************************************************************
// Blanking table in half lines (NTSC odd/even, PAL, M-PAL)
// ****************************************************************
`define VBC_NTSC_ODD_END 11'h02A
`define VBC_NTSC_EVEN_END 11'h239
`define VBC_PAL_ODD_END 11'h02F
`define VBC_PAL_EVEN_END 11'h29E
`define VBC_MPAL_ODD_END 11'h02A
`define VBC_MPAL_EVEN_END 11'h239
`define VBC_LINE_STEP 11'h002

`endif

// ---- core/vbc_pkg.sv ----
// Types for the vertical blank, chroma control and interrupt B register slice.
package vbc_pkg;
	typedef enum logic [1:0] {VBC_STD_NTSC, VBC_STD_PAL, VBC_STD_MPAL} vbc_std_t;
	typedef enum logic [2:0] {VBC_COMB_OFF, VBC_COMB_3QHQ, VBC_COMB_3101, VBC_COMB_2LINE,
		VBC_COMB_AD_QHQ_2L, VBC_COMB_AD_QHQ_NONE, VBC_COMB_AD_101_2L,
		VBC_COMB_AD_101_NONE} vbc_comb_t;
	typedef enum logic [1:0] {VBC_GAIN_ON, VBC_GAIN_RSVD, VBC_GAIN_OFF, VBC_GAIN_FROZEN} vbc_gain_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} vbc_host_req_t;
	typedef struct packed {
		vbc_comb_t comb;
		vbc_gain_t gain;
		logic [1:0] bw_sel;
		logic osc_reset;
		logic bypass_active;
		logic blank_out;
	} vbc_video_ctl_t;
endpackage

// ---- core/vbc_irq_pin.sv ----
// Interrupt B pin driver with selectable polarity and drive style.
`timescale 1ns/100ps
`include "vbcirq_cfg.svh"
module vbc_irq_pin
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic active,
	input wire logic pol_high,
	output logic pin_out,
	output logic pin_oe
);
	logic nxt_out;
	logic nxt_oe;
	logic out_ff;
	logic oe_ff;

	// Open collector when low-active so several devices may share the wire.
	always_comb
	begin
		if (pol_high)
		begin
			nxt_out = active;
			nxt_oe = 1'b1;
		end
		else
		begin
			nxt_out = 1'b0;
			nxt_oe = active;
		end
	end

	// Registered so the pin never glitches on decode.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_ff <= 1'b0;
			oe_ff <= 1'b1;
		end
		else
		begin
			out_ff <= nxt_out;
			oe_ff <= nxt_oe;
		end
	end

	assign pin_out = out_ff;
	assign pin_oe = oe_ff;
endmodule // vbc_irq_pin

// ---- core/vbc_regs.sv ----
// Register bank for blank end, chroma control and interrupt channel B.
`timescale 1ns/100ps
`include "vbcirq_cfg.svh"
module vbc_regs
(
	input wire logic clock,
	input wire logic rst_b,
	input vbc_pkg::vbc_host_req_t host_req,
	output logic [7:0] host_rdata,
	input wire vbc_pkg::vbc_std_t video_std,
	input wire logic field_odd,
	input wire logic [10:0] half_line,
	input wire logic line_start,
	input wire logic marker_line,
	input wire logic gp_pin_blank_sel,
	input wire logic [7:0] irq_events,
	output vbc_pkg::vbc_video_ctl_t video_ctl,
	output logic phase_reset_flag,
	output logic irq_active,
	output logic irq_pin_out,
	output logic irq_pin_oe
);
	import vbc_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0] vblank_end_ff, nxt_vblank_end;
	logic [7:0] chroma_one_ff, nxt_chroma_one;
	logic [1:0] chroma_two_ff, nxt_chroma_two;
	logic [7:0] mask_ff, nxt_mask;
	logic pol_ff, nxt_pol;
	logic [7:0] status_ff, nxt_status;
	logic [7:0] rdata_ff, nxt_rdata;
	logic pend_ff, nxt_pend;
	logic flag_ff, nxt_flag;
	logic osc_ff, nxt_osc;
	logic active_ff, nxt_active;
	logic blank_ff, nxt_blank;
	logic std_seen_ff, nxt_std_seen;
	vbc_video_ctl_t ctl_ff, nxt_ctl;
	logic [10:0] end_line;
	logic [10:0] adj_end;
	logic [7:0] clr_bits;
	logic wr_c1;
	vbc_comb_t comb;

	assign wr_c1 = host_req.wr && host_req.addr == `VBC_OFS_CHROMA_ONE;

	// ****************************************************************
	// Blanking window timing
	// ****************************************************************

	// Standard end line in half lines, picked by standard and field.
	always_comb
	begin
		unique case (video_std)
			VBC_STD_NTSC: end_line = field_odd ? `VBC_NTSC_ODD_END : `VBC_NTSC_EVEN_END;
			VBC_STD_PAL: end_line = field_odd ? `VBC_PAL_ODD_END : `VBC_PAL_EVEN_END;
			VBC_STD_MPAL: end_line = field_odd ? `VBC_MPAL_ODD_END : `VBC_MPAL_EVEN_END;
			default: end_line = field_odd ? `VBC_NTSC_ODD_END : `VBC_NTSC_EVEN_END;
		endcase
		// Signed byte times two half lines; wrap is left to the line counter.
		adj_end = end_line + 11'({{3{vblank_end_ff[7]}}, vblank_end_ff} <<< 1);
	end

	// The window opens at the first half line of the field and closes at the adjusted end.
	always_comb
	begin
		nxt_blank = blank_ff;
		if (line_start)
		begin
			if (half_line == adj_end)
				nxt_blank = 1'b0;
			else if (half_line == 11'h000)
				nxt_blank = 1'b1;
		end
	end

	// ****************************************************************
	// Host writes
	// ****************************************************************
	always_comb
	begin
		nxt_vblank_end = vblank_end_ff;
		nxt_chroma_one = chroma_one_ff;
		nxt_chroma_two = chroma_two_ff;
		nxt_mask = mask_ff;
		nxt_pol = pol_ff;
		nxt_std_seen = 1'b1;
		clr_bits = 8'h00;
		// Chroma control one defaults depend on the standard seen just after reset.
		if (!std_seen_ff)
			nxt_chroma_one = (video_std == VBC_STD_NTSC) ? `VBC_RST_C1_NTSC
				: `VBC_RST_C1_PAL;
		if (host_req.wr)
		begin
			unique case (host_req.addr)
				`VBC_OFS_VBLANK_END: nxt_vblank_end = host_req.wdata;
				`VBC_OFS_CHROMA_ONE: nxt_chroma_one = host_req.wdata & 8'hEF;
				`VBC_OFS_CHROMA_TWO: nxt_chroma_two = host_req.wdata[1:0];
				`VBC_OFS_IRQ_CLEAR: clr_bits = host_req.wdata;
				`VBC_OFS_IRQ_MASK: nxt_mask = host_req.wdata;
				`VBC_OFS_IRQ_CONFIG: nxt_pol = host_req.wdata[0];
				default: ;
			endcase
		end
		// Events set regardless of mask, and win over a same-cycle clear.
		nxt_status = (status_ff & ~clr_bits) | irq_events;
	end

	// ****************************************************************
	// Oscillator reset and genlock phase marker
	// ****************************************************************
	always_comb
	begin
		nxt_osc = wr_c1 && host_req.wdata[`VBC_C1_OSC_RESET_BIT];
		nxt_pend = pend_ff;
		nxt_flag = 1'b0;
		if (pend_ff && marker_line)
		begin
			nxt_flag = 1'b1;
			nxt_pend = 1'b0;
		end
		if (nxt_osc)
			nxt_pend = 1'b1;
		nxt_active = |(nxt_status & nxt_mask);
	end

	// ****************************************************************
	// Decode of chroma controls
	// ****************************************************************
	always_comb
	begin
		if (chroma_one_ff[3])
		begin
			unique case (chroma_one_ff[6:5])
				2'h0: comb = VBC_COMB_AD_QHQ_2L;
				2'h1: comb = VBC_COMB_AD_QHQ_NONE;
				2'h2: comb = VBC_COMB_AD_101_2L;
				2'h3: comb = VBC_COMB_AD_101_NONE;
			endcase
		end
		else if (!chroma_one_ff[2])
			comb = VBC_COMB_OFF;
		else if (chroma_one_ff[7])
			comb = VBC_COMB_2LINE;
		else
			comb = chroma_one_ff[6] ? VBC_COMB_3101 : VBC_COMB_3QHQ;
		nxt_ctl.comb = comb;
		nxt_ctl.gain = vbc_gain_t'(chroma_one_ff[1:0]);
		nxt_ctl.bw_sel = chroma_two_ff;
		nxt_ctl.osc_reset = osc_ff;
		nxt_ctl.bypass_active = blank_ff;
		nxt_ctl.blank_out = blank_ff && gp_pin_blank_sel;
	end

	// ****************************************************************
	// Read data; reserved bits and the clear register read zero
	// ****************************************************************
	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (host_req.rd)
		begin
			unique case (host_req.addr)
				`VBC_OFS_VBLANK_END: nxt_rdata = vblank_end_ff;
				`VBC_OFS_CHROMA_ONE: nxt_rdata = chroma_one_ff;
				`VBC_OFS_CHROMA_TWO: nxt_rdata = {6'h00, chroma_two_ff};
				`VBC_OFS_IRQ_MASK: nxt_rdata = mask_ff;
				`VBC_OFS_IRQ_CONFIG: nxt_rdata = {7'h00, pol_ff};
				`VBC_OFS_IRQ_STATUS: nxt_rdata = status_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// Only registering happens here.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			vblank_end_ff <= `VBC_RST_VBLANK_END;
			chroma_one_ff <= `VBC_RST_C1_NTSC;
			chroma_two_ff <= `VBC_RST_CHROMA_TWO;
			mask_ff <= `VBC_RST_MASK;
			pol_ff <= `VBC_RST_POLARITY;
			status_ff <= 8'h00;
			rdata_ff <= 8'h00;
			pend_ff <= 1'b0;
			flag_ff <= 1'b0;
			osc_ff <= 1'b0;
			active_ff <= 1'b0;
			blank_ff <= 1'b0;
			std_seen_ff <= 1'b0;
			ctl_ff <= '0;
		end
		else
		begin
			vblank_end_ff <= nxt_vblank_end;
			chroma_one_ff <= nxt_chroma_one;
			chroma_two_ff <= nxt_chroma_two;
			mask_ff <= nxt_mask;
			pol_ff <= nxt_pol;
			status_ff <= nxt_status;
			rdata_ff <= nxt_rdata;
			pend_ff <= nxt_pend;
			flag_ff <= nxt_flag;
			osc_ff <= nxt_osc;
			active_ff <= nxt_active;
			blank_ff <= nxt_blank;
			std_seen_ff <= nxt_std_seen;
			ctl_ff <= nxt_ctl;
		end
	end

	// Pin driver registers once more; the active flag is one cycle ahead of the pin.
	vbc_irq_pin u_pin
	(
		.clock(clock),
		.rst_b(rst_b),
		.active(active_ff),
		.pol_high(pol_ff),
		.pin_out(irq_pin_out),
		.pin_oe(irq_pin_oe)
	);

	assign host_rdata = rdata_ff;
	assign video_ctl = ctl_ff;
	assign phase_reset_flag = flag_ff;
	assign irq_active = active_ff;
endmodule // vbc_regs

// ---- tb/vbc_regs_assertions.sv ----
// Checker for the blank, chroma and interrupt B register bank ports.
`timescale 1ns/100ps
module vbc_regs_checker
(
	input wire logic clock,
	input wire logic rst_b,
	input vbc_pkg::vbc_host_req_t host_req,
	input wire logic [7:0] host_rdata,
	input wire logic marker_line,
	input wire logic [7:0] irq_events,
	input vbc_pkg::vbc_video_ctl_t video_ctl,
	input wire logic phase_reset_flag,
	input wire logic irq_active,
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe
);
	import vbc_pkg::*;
	logic osc_wr;
	// ****************************************************************
	// Properties
	// ****************************************************************
	// A write of one to the oscillator reset bit is the only cause of the pulse.
	assign osc_wr = host_req.wr && host_req.addr == 8'h1A && host_req.wdata[4];
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	osc_pulse_a: assert property (video_ctl.osc_reset |=> !video_ctl.osc_reset)
		else $error("oscillator reset pulse too long");
	osc_cause_a: assert property (video_ctl.osc_reset |-> $past(osc_wr) || $past(osc_wr, 2))
		else $error("oscillator reset without a write");
	phase_cause_a: assert property (phase_reset_flag |-> $past(marker_line) || $past(marker_line, 2))
		else $error("phase flag off the marker line");
	pin_float_a: assert property (!irq_pin_oe |-> !$past(irq_active))
		else $error("pin floats while interrupt active");
	pin_high_a: assert property (irq_pin_oe && irq_pin_out |-> $past(irq_active))
		else $error("pin high while interrupt inactive");
	irq_rise_a: assert property ($rose(irq_active) |-> $past(|irq_events) ||
		$past(|irq_events, 2) || $past(host_req.wr) || $past(host_req.wr, 2))
		else $error("interrupt rose without a cause");
	clear_read_a: assert property (host_req.rd && host_req.addr == 8'h1C ##1 !host_req.rd
		|=> host_rdata == 8'h00)
		else $error("clear register read nonzero");
	comb_off_a: assert property (host_req.wr && host_req.addr == 8'h1A &&
		host_req.wdata[3:2] == 2'b00 ##1 !host_req.wr |=> video_ctl.comb == VBC_COMB_OFF)
		else $error("comb not disabled");
	bw_follow_a: assert property (host_req.wr && host_req.addr == 8'h1B ##1 !host_req.wr
		|=> video_ctl.bw_sel == $past(host_req.wdata[1:0], 2))
		else $error("bandwidth select mismatch");
endmodule // vbc_regs_checker

// ---- tb/vbc_host_model.sv ----
// Host processor model that issues single-cycle register strobes.
`timescale 1ns/100ps
module vbc_host_model
(
	input wire logic clock,
	input wire logic [7:0] host_rdata,
	output vbc_pkg::vbc_host_req_t host_req
);
	import vbc_pkg::*;
	// ****************************************************************
	// Access tasks
	// ****************************************************************
	// Released lines carry inverted values so stale data never looks valid.
	initial host_req = '0;
	// Channel A polarity, which the host copies from each channel B config write; a reset does not reload it.
	logic pol_chan_a = 1'b1;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		host_req <= '{1'b1, 1'b0, a, d};
		if (a == 8'h1E)
			pol_chan_a = d[0];
		@(posedge clock);
		host_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	// Read data is taken two edges after the strobe edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		host_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		host_req <= '{1'b0, 1'b0, ~a, 8'hFF};
		@(posedge clock);
		#1;
		d = host_rdata;
	endtask
endmodule // vbc_host_model

// ---- tb/vbc_regs_tb.sv ----
// Testbench for the blank, chroma and interrupt B register bank.
`timescale 1ns/100ps
module vbc_regs_tb;
	import vbc_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic marker_line = 1'b0;
	logic [7:0] irq_events = 8'h00;
	logic [7:0] host_rdata, d, m;
	logic phase_reset_flag, irq_active, irq_pin_out, irq_pin_oe;
	vbc_host_req_t host_req;
	vbc_std_t video_std = VBC_STD_NTSC;
	vbc_video_ctl_t video_ctl;
	logic [10:0] half_line = 11'h000;
	logic line_start = 1'b0;
	logic gp_sel = 1'b1;
	int mismatches = 0, tests_run = 0, cycles = 0, flags = 0, oscs = 0;
	logic [7:0] ra [8] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h85, 8'h40};
	logic [7:0] re [8] = '{8'h00, 8'h2C, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
	logic [7:0] cw [9] = '{8'hE1, 8'h05, 8'h26, 8'h47, 8'h84, 8'h0B, 8'h29, 8'h4A, 8'hEF};
	vbc_comb_t ce [9] = '{VBC_COMB_OFF, VBC_COMB_3QHQ, VBC_COMB_3QHQ, VBC_COMB_3101,
		VBC_COMB_2LINE, VBC_COMB_AD_QHQ_2L, VBC_COMB_AD_QHQ_NONE, VBC_COMB_AD_101_2L,
		VBC_COMB_AD_101_NONE};
	// ****************************************************************
	// Design, host and helpers
	// ****************************************************************
	// Field parity is held odd; the line inputs come from the line_at task.
	vbc_regs DUT (.clock(clock), .rst_b(rst_b), .host_req(host_req), .host_rdata(host_rdata),
		.video_std(video_std), .field_odd(1'b1), .half_line(half_line), .line_start(line_start),
		.marker_line(marker_line), .gp_pin_blank_sel(gp_sel), .irq_events(irq_events),
		.video_ctl(video_ctl), .phase_reset_flag(phase_reset_flag), .irq_active(irq_active),
		.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
	vbc_host_model host (.clock(clock), .host_rdata(host_rdata), .host_req(host_req));
	always #5 clock = ~clock;
	// Strobes are counted mid-cycle, away from the edge that launches them.
	always @(negedge clock)
	begin
		if (phase_reset_flag === 1'b1)
			flags++;
		if (video_ctl.osc_reset === 1'b1)
			oscs++;
	end
	// Cycle ceiling.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got %0h exp %0h", $time, got, exp);
			mismatches++;
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d);
		chk(d, exp);
	endtask
	task automatic pulse(input logic [7:0] ev, input logic mk);
		@(posedge clock);
		irq_events <= ev;
		marker_line <= mk;
		@(posedge clock);
		irq_events <= 8'h00;
		marker_line <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask
	// One half-line start strobe, then time for the window and control struct to settle.
	task automatic line_at(input logic [10:0] hl, input logic gs);
		@(posedge clock);
		half_line <= hl;
		line_start <= 1'b1;
		gp_sel <= gs;
		@(posedge clock);
		line_start <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic do_reset(input vbc_std_t s);
		video_std <= s;
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
	endtask
	task automatic summarize();
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		do_reset(VBC_STD_NTSC);
		host.wr(8'h40, 8'hFF);
		for (int i = 0; i < 8; i++)
			rd_chk(ra[i], re[i]);
		host.wr(8'h19, 8'h80);
		rd_chk(8'h19, 8'h80);
		// Odd field ends at half line 2A; two lines later is 2E, one line earlier is 28.
		host.wr(8'h19, 8'h02);
		line_at(11'h000, 1'b1);
		chk({6'h00, video_ctl.blank_out, video_ctl.bypass_active}, 8'h03);
		line_at(11'h02A, 1'b1);
		chk({6'h00, video_ctl.blank_out, video_ctl.bypass_active}, 8'h03);
		line_at(11'h02E, 1'b1);
		chk({6'h00, video_ctl.blank_out, video_ctl.bypass_active}, 8'h00);
		host.wr(8'h19, 8'hFF);
		line_at(11'h000, 1'b0);
		chk({6'h00, video_ctl.blank_out, video_ctl.bypass_active}, 8'h01);
		line_at(11'h028, 1'b1);
		chk({6'h00, video_ctl.blank_out, video_ctl.bypass_active}, 8'h00);
		host.wr(8'h1E, 8'hFE);
		rd_chk(8'h1E, 8'h00);
		host.wr(8'h1E, 8'hFF);
		rd_chk(8'h1E, 8'h01);
		for (int i = 0; i < 9; i++)
		begin
			host.wr(8'h1A, cw[i]);
			host.wr(8'h1B, {6'h3F, i[1:0]});
			rd_chk(8'h1A, cw[i] & 8'hEF);
			rd_chk(8'h1B, {6'h00, i[1:0]});
			chk({5'h00, video_ctl.comb}, {5'h00, ce[i]});
			chk({6'h00, video_ctl.gain}, {6'h00, cw[i][1:0]});
			chk({6'h00, video_ctl.bw_sel}, {6'h00, i[1:0]});
		end
		host.wr(8'h85, 8'hFF);
		rd_chk(8'h85, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			m = 8'h01 << i;
			pulse(m, 1'b0);
			rd_chk(8'h85, m);
			chk({7'h00, irq_active}, 8'h00);
			host.wr(8'h1D, m);
			pulse(8'h00, 1'b0);
			chk({5'h00, irq_active, irq_pin_oe, irq_pin_out}, 8'h07);
			host.wr(8'h1C, ~m);
			rd_chk(8'h85, m);
			host.wr(8'h1C, m);
			pulse(8'h00, 1'b0);
			chk({5'h00, irq_active, irq_pin_oe, irq_pin_out}, 8'h02);
			host.wr(8'h1D, 8'h00);
		end
		host.wr(8'h1D, 8'h80);
		fork
			host.wr(8'h1C, 8'h80);
			pulse(8'h80, 1'b0);
		join
		rd_chk(8'h85, 8'h80);
		host.wr(8'h1E, 8'h00);
		pulse(8'h00, 1'b0);
		chk({5'h00, irq_active, irq_pin_oe, irq_pin_out}, 8'h06);
		host.wr(8'h1C, 8'h80);
		pulse(8'h00, 1'b0);
		chk({6'h00, irq_active, irq_pin_oe}, 8'h00);
		do_reset(VBC_STD_PAL);
		rd_chk(8'h1A, 8'h6C);
		chk({5'h00, video_ctl.comb}, {5'h00, VBC_COMB_AD_101_NONE});
		pulse(8'h00, 1'b1);
		chk(flags[7:0], 8'h00);
		host.wr(8'h1A, 8'h7C);
		rd_chk(8'h1A, 8'h6C);
		pulse(8'h00, 1'b1);
		pulse(8'h00, 1'b1);
		chk(flags[7:0], 8'h01);
		chk(oscs[7:0], 8'h01);
		summarize();
	end
endmodule // vbc_regs_tb
bind vbc_regs vbc_regs_checker chk_i (.clock(clock), .rst_b(rst_b), .host_req(host_req),
	.host_rdata(host_rdata), .marker_line(marker_line), .irq_events(irq_events),
	.video_ctl(video_ctl), .phase_reset_flag(phase_reset_flag), .irq_active(irq_active),
	.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
